/* core/bfpt_core.sv */
// Breaker-failure supervision: pick-up, blocking, retrip and failure timers.
// Assumes measurements, triggers and eval_i come from logic on core_clk_i.
//
// Operation
// [RULE_01] Each evaluation checks all phases and the chosen residual.
// [RULE_02] Pick-up when one, two or all phases exceed the phase threshold.
// [RULE_03] A picked channel releases only below 97 percent of its threshold.
// [RULE_04] One phase threshold serves all three phases.
// [RULE_05] Residual source: 0 none, 1 input one, 2 input two, 3 calculated.
// [RULE_06] Mode code 0..10 combines current, output and signal triggers.
// [RULE_07] Phase threshold in 0.01 nominal steps, default 0.20.
// [RULE_08] Residual threshold in 0.001 nominal steps, default 1.200.
// [RULE_09] Start rises on pick-up only while blocking is inactive.
// [RULE_10] Binary trigger pick-up follows the signal without added delay.
// [RULE_11] Blocking is sampled at the start of each evaluation.
// [RULE_12] Blocked pick-up raises blocked output and starts no timing.
// [RULE_13] Blocking after start drops start and releases as on reset.
// [RULE_14] Blocking activation emits an event with current and fault type.
// [RULE_15] Blocking source asserts at least 5 ms before delay expiry.
// [RULE_16] Forcing switch drives blocking when forcing test mode is enabled.
// [RULE_17] One pick-up condition starts retrip and failure timers together.
// [RULE_18] Failure delay should exceed retrip plus breaker and release times.
// [RULE_19] Retrip enable, default yes; disabled suppresses retrip output.
// [RULE_20] Retrip asserts after start persists for retrip delay, 5 ms steps.
// [RULE_21] Failure output asserts after start persists for failure delay.
// [RULE_22] State code: normal, start, retrip, failure, blocked.
// [RULE_23] Readable node mode code: on, blocked, test, test blocked, off.
// [RULE_24] Four outputs: start, retrip, failure, blocked.
// [RULE_25] Both timers clear once current drops below thresholds.
// [RULE_26] Timers count evaluation cycles and assert when reaching the delay.
`timescale 1ns/1ns
module bfpt_core
    import bfpt_pkg::*;
#(
    parameter logic [CNT_W-1:0] RT_DLY_RST = CNT_W'(RT_DLY_STEPS),
    parameter logic [CNT_W-1:0] BF_DLY_RST = CNT_W'(BF_DLY_STEPS)
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic eval_i,
    input wire bfpt_meas_type meas_i,
    input wire logic output_trig_i,
    input wire logic signal_trig_i,
    input wire logic block_i,
    output bfpt_outs_type outs_o,
    output logic block_event_o
);

    logic [31:0] ctrl_q;
    logic [15:0] ph_thr_q;
    logic [15:0] res_thr_q;
    logic [CNT_W-1:0] rt_dly_q;
    logic [CNT_W-1:0] bf_dly_q;
    logic [3:0] picked_q;
    logic [3:0] picked_d;
    logic blk_now;
    logic pick_now;
    logic cur_pick;
    logic [CNT_W-1:0] rt_cnt_q;
    logic [CNT_W-1:0] bf_cnt_q;
    logic [CNT_W-1:0] rt_cnt_d;
    logic [CNT_W-1:0] bf_cnt_d;
    logic [3:0] ftype_q;
    logic [7:0] evt_cnt_q;
    logic [15:0] evt_cur_q;
    logic [2:0] fsc;
    logic [2:0] node;
    logic [15:0] res_mag;
    logic node_off;
    logic wr_en;
    logic rd_hit;

    assign node = ctrl_q[CTRL_NODE_LSB +: 3];
    assign node_off = (node == NODE_OFF);

    // Held channels compare against 97 percent, idle ones against the full
    // threshold; widened products keep the hysteresis exact
    function automatic logic over_thr(input logic [15:0] mag,
                                      input logic [15:0] thr,
                                      input logic held);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = 24'(mag) * 24'(FULL_PCT);
        rhs = 24'(thr) * 24'(held ? RESET_PCT : FULL_PCT);
        over_thr = held ? (lhs >= rhs) : (lhs > rhs);
    endfunction

    function automatic logic combine(input logic [3:0] m, input logic c,
                                     input logic o, input logic s);
        case (m)
            4'h0: combine = c;
            4'h1: combine = o;
            4'h2: combine = s;
            4'h3: combine = c & o;
            4'h4: combine = c | o;
            4'h5: combine = c & s;
            4'h6: combine = c | s;
            4'h7: combine = s & o;
            4'h8: combine = s | o;
            4'h9: combine = c | o | s;
            4'hA: combine = c & o & s;
            default: combine = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] max16(input logic [15:0] a,
                                          input logic [15:0] b);
        max16 = (a > b) ? a : b;
    endfunction

    // Residual source select
    always_comb begin
        case (ctrl_q[CTRL_RSEL_LSB +: 2])
            RSEL_ONE: res_mag = meas_i.residual_input_one; // [RULE_05]
            RSEL_TWO: res_mag = meas_i.residual_input_two;
            RSEL_CALC: res_mag = meas_i.calculated_residual_current;
            default: res_mag = 16'h0000;
        endcase
    end

    // One shared phase threshold, per-channel hysteresis
    always_comb begin
        picked_d[0] = over_thr(meas_i.ph_a, ph_thr_q, picked_q[0]); // [RULE_04]
        picked_d[1] = over_thr(meas_i.ph_b, ph_thr_q, picked_q[1]); // [RULE_03]
        picked_d[2] = over_thr(meas_i.ph_c, ph_thr_q, picked_q[2]); // [RULE_01]
        picked_d[3] = (ctrl_q[CTRL_RSEL_LSB +: 2] != RSEL_NONE) &&
                      over_thr(res_mag, res_thr_q, picked_q[3]);
        if (node_off) begin
            picked_d = 4'h0;
        end
    end

    // Any one, two or all channels over threshold counts as current pick-up
    assign cur_pick = |picked_d; // [RULE_02]
    // Binary triggers go straight in, so they add no delay
    assign pick_now = !node_off && combine(ctrl_q[CTRL_MODE_LSB +: 4],
        cur_pick, output_trig_i, signal_trig_i); // [RULE_10] [RULE_06]
    // Fresh blocking level is used in the same evaluation it is sampled in
    assign blk_now = block_i || node == NODE_BLOCKED ||
        node == NODE_TEST_BLK ||
        (ctrl_q[CTRL_FEN_BIT] && ctrl_q[CTRL_FBLK_BIT]); // [RULE_16]

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            picked_q <= 4'h0;
        end else if (eval_i) begin
            picked_q <= picked_d;
        end
    end

    // Counters saturate at their delay; a zero delay operates at once
    always_comb begin
        rt_cnt_d = (rt_cnt_q < rt_dly_q) ? rt_cnt_q + 1'b1 : rt_cnt_q;
        bf_cnt_d = (bf_cnt_q < bf_dly_q) ? bf_cnt_q + 1'b1 : bf_cnt_q;
    end

    // Start, blocked and both timers share one pick-up condition
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            outs_o <= '0;
            rt_cnt_q <= '0;
            bf_cnt_q <= '0;
        end else if (eval_i) begin
            if (pick_now && !blk_now) begin // [RULE_11]
                outs_o.start <= 1'b1; // [RULE_09]
                outs_o.blocked <= 1'b0;
                rt_cnt_q <= rt_cnt_d; // [RULE_17] [RULE_26]
                bf_cnt_q <= bf_cnt_d;
                outs_o.retrip <= ctrl_q[CTRL_RTEN_BIT] &&
                                 (rt_cnt_d >= rt_dly_q); // [RULE_20] [RULE_19]
                outs_o.breaker_failure_out <=
                    (bf_cnt_d >= bf_dly_q); // [RULE_21]
            end else begin
                // Blocked or released: drop start, retrip and failure, flag blocked on pick-up, clear timers
                outs_o.start <= 1'b0; // [RULE_13]
                outs_o.retrip <= 1'b0;
                outs_o.breaker_failure_out <= 1'b0;
                outs_o.blocked <= pick_now; // [RULE_12] [RULE_24]
                rt_cnt_q <= '0; // [RULE_25]
                bf_cnt_q <= '0;
            end
        end else if (!ctrl_q[CTRL_RTEN_BIT]) begin
            outs_o.retrip <= 1'b0; // [RULE_19]
        end
    end

    // Blocking event with fault type and the largest phase current at that moment
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            block_event_o <= 1'b0;
            ftype_q <= 4'h0;
            evt_cnt_q <= 8'h00;
            evt_cur_q <= 16'h0000;
        end else begin
            block_event_o <= eval_i && pick_now && blk_now &&
                             !outs_o.blocked; // [RULE_14]
            if (eval_i && pick_now && blk_now && !outs_o.blocked) begin
                ftype_q <= picked_d;
                evt_cnt_q <= evt_cnt_q + 8'h01;
                evt_cur_q <= max16(max16(meas_i.ph_a, meas_i.ph_b),
                                   meas_i.ph_c);
            end
        end
    end

    // Failure outranks retrip, which outranks start
    always_comb begin
        if (outs_o.breaker_failure_out) begin
            fsc = FSC_BF; // [RULE_22]
        end else if (outs_o.retrip) begin
            fsc = FSC_RETRIP;
        end else if (outs_o.start) begin
            fsc = FSC_START;
        end else if (outs_o.blocked) begin
            fsc = FSC_BLOCKED;
        end else begin
            fsc = FSC_NORMAL;
        end
    end

    // APB slave: one wait state, writes land on the ready edge
    assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
    assign rd_hit = (paddr_i[7:5] == 3'h0) && (paddr_i[1:0] == 2'h0);

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= psel_i && penable_i && !pready_o;
            pslverr_o <= psel_i && penable_i && !pready_o && !rd_hit;
            prdata_o <= 32'h0000_0000;
            if (psel_i && penable_i && !pready_o && !pwrite_i) begin
                case (paddr_i)
                    CTRL_OFS: prdata_o <= ctrl_q;
                    PH_THR_OFS: prdata_o <= {16'h0000, ph_thr_q};
                    RES_THR_OFS: prdata_o <= {16'h0000, res_thr_q};
                    RT_DLY_OFS: prdata_o <= {16'h0000, rt_dly_q};
                    BF_DLY_OFS: prdata_o <= {16'h0000, bf_dly_q};
                    STATUS_OFS: prdata_o <= {19'h0, |picked_q, outs_o.blocked,
                        outs_o.breaker_failure_out, outs_o.retrip,
                        outs_o.start, 1'b0, node, 1'b0, fsc}; // [RULE_23]
                    EVENT_OFS: prdata_o <= {16'h0000, evt_cnt_q, 4'h0,
                                            ftype_q};
                    EVT_CUR_OFS: prdata_o <= {16'h0000, evt_cur_q};
                    default: prdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Settings; unused control bits stay zero
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ctrl_q <= 32'(MODE_RST) | (32'(RSEL_RST) << CTRL_RSEL_LSB) |
                      (32'(RTEN_RST) << CTRL_RTEN_BIT) |
                      (32'(NODE_RST) << CTRL_NODE_LSB);
            ph_thr_q <= PH_THR_RST; // [RULE_07]
            res_thr_q <= RES_THR_RST; // [RULE_08]
            rt_dly_q <= RT_DLY_RST;
            bf_dly_q <= BF_DLY_RST;
        end else if (wr_en) begin
            case (paddr_i)
                CTRL_OFS: ctrl_q <= pwdata_i & 32'h0000_377F;
                PH_THR_OFS: ph_thr_q <= pwdata_i[15:0];
                RES_THR_OFS: res_thr_q <= pwdata_i[15:0];
                RT_DLY_OFS: rt_dly_q <= pwdata_i[CNT_W-1:0];
                BF_DLY_OFS: bf_dly_q <= pwdata_i[CNT_W-1:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    sequence s_eval_blocked;
        eval_i && blk_now;
    endsequence

    sequence s_eval_clear;
        eval_i && !pick_now;
    endsequence

    sequence s_apb_wait;
        psel_i && penable_i && !pready_o;
    endsequence

    a_start_not_blocked: assert property (@(posedge core_clk_i) // [RULE_09]
        disable iff (!resetn_i) !(outs_o.start && outs_o.blocked))
        else $error("start and blocked both high");

    a_block_drops_start: assert property (@(posedge core_clk_i) // [RULE_13]
        disable iff (!resetn_i) s_eval_blocked |=>
        !outs_o.start && rt_cnt_q == 0 && bf_cnt_q == 0)
        else $error("blocking did not drop start");

    a_block_flags_out: assert property (@(posedge core_clk_i) // [RULE_12]
        disable iff (!resetn_i) s_eval_blocked ##0 pick_now |=>
        outs_o.blocked)
        else $error("blocked output missing");

    a_timers_clear: assert property (@(posedge core_clk_i) // [RULE_25]
        disable iff (!resetn_i) s_eval_clear |=>
        rt_cnt_q == 0 && bf_cnt_q == 0 && !outs_o.start)
        else $error("timers not cleared on release");

    a_retrip_gated: assert property (@(posedge core_clk_i) // [RULE_20]
        disable iff (!resetn_i) outs_o.retrip |->
        outs_o.start && rt_cnt_q >= rt_dly_q)
        else $error("retrip without elapsed delay");

    a_retrip_disable: assert property (@(posedge core_clk_i) // [RULE_19]
        disable iff (!resetn_i) !ctrl_q[CTRL_RTEN_BIT] |=> !outs_o.retrip)
        else $error("retrip while disabled");

    a_bf_delay: assert property (@(posedge core_clk_i) // [RULE_21]
        disable iff (!resetn_i) $rose(outs_o.breaker_failure_out) |->
        bf_cnt_q >= bf_dly_q && $past(eval_i))
        else $error("failure output before its delay");

    a_timer_step: assert property (@(posedge core_clk_i) // [RULE_26]
        disable iff (!resetn_i) outs_o.start && !eval_i |=>
        $stable(rt_cnt_q) && $stable(bf_cnt_q))
        else $error("timer moved outside an evaluation");

    a_state_code: assert property (@(posedge core_clk_i) // [RULE_22]
        disable iff (!resetn_i) outs_o.breaker_failure_out |->
        fsc == FSC_BF)
        else $error("state code not failure");

    a_block_event: assert property (@(posedge core_clk_i) // [RULE_14]
        disable iff (!resetn_i) $rose(outs_o.blocked) |->
        block_event_o ##1 !block_event_o)
        else $error("blocking event missing");

    a_apb_answer: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i) s_apb_wait |=> pready_o ##1 !pready_o)
        else $error("apb answer not one wait state");

endmodule

/* core/bfpt_pkg.sv */
// Shared constants and types for breaker-failure pick-up and timing.
// Assumes a single 10 MHz clock and an APB register port.
package bfpt_pkg;

    localparam int ADDR_W = 8;
    localparam int MAG_W = 16;
    localparam int CNT_W = 16;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PH_THR_OFS = 8'h04;
    localparam logic [7:0] RES_THR_OFS = 8'h08;
    localparam logic [7:0] RT_DLY_OFS = 8'h0C;
    localparam logic [7:0] BF_DLY_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] EVENT_OFS = 8'h18;
    localparam logic [7:0] EVT_CUR_OFS = 8'h1C;

    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RSEL_LSB = 4;
    localparam int CTRL_RTEN_BIT = 6;
    localparam int CTRL_NODE_LSB = 8;
    localparam int CTRL_FEN_BIT = 12;
    localparam int CTRL_FBLK_BIT = 13;

    // Residual source select
    localparam logic [1:0] RSEL_NONE = 2'h0;
    localparam logic [1:0] RSEL_ONE = 2'h1;
    localparam logic [1:0] RSEL_TWO = 2'h2;
    localparam logic [1:0] RSEL_CALC = 2'h3;

    // Node mode codes
    localparam logic [2:0] NODE_ON = 3'h1;
    localparam logic [2:0] NODE_BLOCKED = 3'h2;
    localparam logic [2:0] NODE_TEST = 3'h3;
    localparam logic [2:0] NODE_TEST_BLK = 3'h4;
    localparam logic [2:0] NODE_OFF = 3'h5;

    // Function state codes
    localparam logic [2:0] FSC_NORMAL = 3'h0;
    localparam logic [2:0] FSC_START = 3'h1;
    localparam logic [2:0] FSC_RETRIP = 3'h2;
    localparam logic [2:0] FSC_BF = 3'h3;
    localparam logic [2:0] FSC_BLOCKED = 3'h4;

    // Reset ratio as a fraction of the threshold, in percent
    localparam logic [7:0] RESET_PCT = 8'h61;
    localparam logic [7:0] FULL_PCT = 8'h64;

    // Timing: delays counted in evaluation cycles of EVAL_PERIOD_MS
    localparam int EVAL_PERIOD_MS = 5;
    localparam int RT_DLY_MS = 100;
    localparam int BF_DLY_MS = 200;
    localparam int BLOCK_LEAD_MS = 5;
    localparam int RT_DLY_STEPS = RT_DLY_MS / EVAL_PERIOD_MS;
    localparam int BF_DLY_STEPS = BF_DLY_MS / EVAL_PERIOD_MS;

    // Reset values
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [1:0] RSEL_RST = RSEL_NONE;
    localparam logic RTEN_RST = 1'b1;
    localparam logic [2:0] NODE_RST = NODE_ON;
    localparam logic [15:0] PH_THR_RST = 16'h0014;
    localparam logic [15:0] RES_THR_RST = 16'h04B0;

    typedef struct packed {
        logic [MAG_W-1:0] ph_a;
        logic [MAG_W-1:0] ph_b;
        logic [MAG_W-1:0] ph_c;
        logic [MAG_W-1:0] residual_input_one;
        logic [MAG_W-1:0] residual_input_two;
        logic [MAG_W-1:0] calculated_residual_current;
    } bfpt_meas_type;

    typedef struct packed {
        logic start;
        logic retrip;
        logic breaker_failure_out;
        logic blocked;
    } bfpt_outs_type;

endpackage

/* dv/bfpt_core_tb.sv */
// Self-checking bench for breaker-failure pick-up and timing.
// Assumes bfpt_pkg, bfpt_core and the far-side model are compiled first.
`timescale 1ns/1ns
module bfpt_core_tb;
    import bfpt_pkg::*;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, err, eval_i = 1'b0, block_i = 1'b0;
    logic trip_req = 1'b0, sig_req = 1'b0, coil_ok = 1'b0;
    logic output_trig_i, signal_trig_i, block_event_o, ev_seen;
    bfpt_meas_type fault_meas = '0, meas_i;
    bfpt_outs_type outs_o;
    int failures = 0, num_checks = 0;
    // Mode code, then expected start for each {current, output, signal}
    logic [11:0] mode_rows [0:11] = '{12'h0F0, 12'h1CC, 12'h2AA,
        12'h3C0, 12'h4FC, 12'h5A0, 12'h6FA, 12'h788, 12'h8EE, 12'h9FE,
        12'hA80, 12'hB00};
    // Node mode code, then expected outputs with current picked
    logic [6:0] node_rows [0:4] = '{7'h21, 7'h38, 7'h41, 7'h50, 7'h18};

    // Short delays keep the run brief; BF exceeds RT plus clearing time
    bfpt_core #(.RT_DLY_RST(16'h0002), .BF_DLY_RST(16'h0004)) bfpt_core_i (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .eval_i(eval_i), .meas_i(meas_i),
        .output_trig_i(output_trig_i), .signal_trig_i(signal_trig_i),
        .block_i(block_i), .outs_o(outs_o), .block_event_o(block_event_o));
    bfpt_far_model bfpt_far_model_i (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .fault_meas_i(fault_meas), .trip_req_i(trip_req),
        .sig_req_i(sig_req), .coil_ok_i(coil_ok), .outs_i(outs_o),
        .meas_o(meas_i), .output_trig_o(output_trig_i),
        .signal_trig_o(signal_trig_i));

    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end

    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) begin
            failures++;
            $display("MISMATCH t=%0t no pready", $time);
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Read one register and compare a field of it
    task automatic fld(input logic [7:0] a, input int sh,
                       input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk((rd >> sh) & m, e);
    endtask

    // One evaluation strobe, then the outputs it produced
    task automatic ev(input bfpt_outs_type e);
        @(posedge core_clk_i);
        eval_i <= 1'b1;
        @(posedge core_clk_i);
        eval_i <= 1'b0;
        @(negedge core_clk_i);
        ev_seen = block_event_o;
        chk(outs_o, e);
    endtask

    task automatic put(input bfpt_meas_type m, input logic o,
                       input logic s);
        @(posedge core_clk_i);
        fault_meas <= m;
        trip_req <= o;
        sig_req <= s;
    endtask

    task automatic setblk(input logic v);
        @(posedge core_clk_i);
        block_i <= v;
    endtask

    function automatic logic [31:0] ctl(input logic [3:0] m,
        input logic [1:0] r, input logic rt, input logic [2:0] nd,
        input logic [1:0] f);
        return {18'h0, f, 1'b0, nd, 1'b0, rt, r, m};
    endfunction

    // Level v on channel p: 0..2 phases, 3..5 residual sources
    function automatic bfpt_meas_type one(input int p,
                                          input logic [15:0] v);
        bfpt_meas_type m;
        m = '0;
        m[MAG_W*(5-p) +: MAG_W] = v;
        return m;
    endfunction

    initial begin
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        chk(outs_o, 32'h0);
        fld(CTRL_OFS, 0, 32'h377F, 32'h140);
        fld(PH_THR_OFS, 0, 32'hFFFF, 32'h14);
        fld(RES_THR_OFS, 0, 32'hFFFF, 32'h4B0);
        fld(RT_DLY_OFS, 0, 32'hFFFF, 32'h2);
        fld(BF_DLY_OFS, 0, 32'hFFFF, 32'h4);
        fld(8'h20, 0, 32'hFFFFFFFF, 32'h0);
        chk(err, 1'b1);
        for (int r = 0; r < 12; r++) begin
            wr(CTRL_OFS, ctl(mode_rows[r][11:8], 2'h0, 1'b1, NODE_ON, 2'h0));
            for (int k = 0; k < 8; k++) begin
                put(one(0, k[2] ? 16'h0015 : 16'h0000), k[1], k[0]);
                ev({mode_rows[r][k], 3'b000});
                put('0, 1'b0, 1'b0);
                ev(4'b0000);
            end
        end
        // Hysteresis is easiest to see on a round threshold of 100
        wr(CTRL_OFS, ctl(4'h0, 2'h0, 1'b1, NODE_ON, 2'h0));
        wr(PH_THR_OFS, 32'h64);
        put(one(0, 16'h0064), 1'b0, 1'b0);
        ev(4'b0000);
        put(one(0, 16'h0065), 1'b0, 1'b0);
        ev(4'b1000);
        put(one(0, 16'h0061), 1'b0, 1'b0);
        ev(4'b1100);
        put(one(0, 16'h0060), 1'b0, 1'b0);
        ev(4'b0000);
        for (int p = 1; p < 3; p++) begin
            put(one(p, 16'h0065), 1'b0, 1'b0);
            ev(4'b1000);
            put('0, 1'b0, 1'b0);
            ev(4'b0000);
        end
        for (int s = 1; s < 4; s++) begin
            for (int r = 0; r < 4; r++) begin
                wr(CTRL_OFS, ctl(4'h0, 2'(r), 1'b1, NODE_ON, 2'h0));
                put(one(2 + s, 16'h04B1), 1'b0, 1'b0);
                ev({r == s, 3'b000});
                put('0, 1'b0, 1'b0);
                ev(4'b0000);
            end
        end
        for (int rt = 1; rt >= 0; rt--) begin
            wr(CTRL_OFS, ctl(4'h0, 2'h0, rt[0], NODE_ON, 2'h0));
            put(one(0, 16'h0065), 1'b0, 1'b0);
            for (int k = 1; k <= 4; k++) begin
                ev({1'b1, rt[0] && k >= 2, k >= 4, 1'b0});
                fld(STATUS_OFS, 0, 32'h7, k >= 4 ? FSC_BF : (rt[0] && k >= 2)
                    ? FSC_RETRIP : FSC_START);
            end
            put('0, 1'b0, 1'b0);
            ev(4'b0000);
        end
        wr(CTRL_OFS, ctl(4'h0, 2'h0, 1'b1, NODE_ON, 2'h0));
        put(one(0, 16'h0065), 1'b0, 1'b0);
        // A block pulse between strobes is never sampled
        setblk(1'b1);
        setblk(1'b0);
        ev(4'b1000);
        // Block raised a full strobe before the retrip delay ends
        setblk(1'b1);
        ev(4'b0001);
        chk(ev_seen, 1'b1);
        ev(4'b0001);
        chk(ev_seen, 1'b0);
        fld(STATUS_OFS, 0, 32'h7, FSC_BLOCKED);
        fld(EVENT_OFS, 8, 32'hFF, 32'h1);
        fld(EVT_CUR_OFS, 0, 32'hFFFF, 32'h65);
        setblk(1'b0);
        ev(4'b1000);
        ev(4'b1100);
        wr(CTRL_OFS, ctl(4'h0, 2'h0, 1'b1, NODE_ON, 2'h3));
        ev(4'b0001);
        wr(CTRL_OFS, ctl(4'h0, 2'h0, 1'b1, NODE_ON, 2'h2));
        ev(4'b1000);
        for (int i = 0; i < 5; i++) begin
            wr(CTRL_OFS, ctl(4'h0, 2'h0, 1'b1, node_rows[i][6:4], 2'h0));
            ev(node_rows[i][3:0]);
            fld(STATUS_OFS, 4, 32'h7, 32'(node_rows[i][6:4]));
        end
        put('0, 1'b0, 1'b0);
        ev(4'b0000);
        // Working spare coil: retrip clears the fault before failure
        @(posedge core_clk_i);
        coil_ok <= 1'b1;
        put(one(0, 16'h0065), 1'b1, 1'b0);
        ev(4'b1000);
        ev(4'b1100);
        ev(4'b0000);
        ev(4'b0000);
        // Mid-run reset must drop a running timer and restore settings
        put('0, 1'b0, 1'b0);
        put(one(0, 16'h0065), 1'b0, 1'b0);
        ev(4'b1000);
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        chk(outs_o, 32'h0);
        fld(CTRL_OFS, 0, 32'h377F, 32'h140);
        fld(PH_THR_OFS, 0, 32'hFFFF, 32'h14);
        fld(RT_DLY_OFS, 0, 32'hFFFF, 32'h2);
        ev(4'b1000);
        report_and_stop();
    end
endmodule

/* dv/bfpt_far_model.sv */
// Far-side model: upstream trip sources and the breaker coils.
// Assumes the bench sets fault levels and trip requests after clock edges.
`timescale 1ns/1ns
module bfpt_far_model
    import bfpt_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire bfpt_meas_type fault_meas_i,
    input wire logic trip_req_i,
    input wire logic sig_req_i,
    input wire logic coil_ok_i,
    input wire bfpt_outs_type outs_i,
    output bfpt_meas_type meas_o,
    output logic output_trig_o,
    output logic signal_trig_o
);
    logic open_q;
    // Spare coil opens the breaker one cycle after retrip
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || fault_meas_i == '0) begin
            open_q <= 1'b0;
        end else if (coil_ok_i && outs_i.retrip) begin
            open_q <= 1'b1;
        end
    end
    // An open breaker carries no current, so the primary trip ends too
    assign meas_o = open_q ? '0 : fault_meas_i;
    assign output_trig_o = trip_req_i & ~open_q;
    assign signal_trig_o = sig_req_i & ~open_q;
endmodule
